// ---- core/fsl_pkg.sv ----
// shared constants and types for the flash security and lockout recovery block
package fsl_pkg;
    // instruction register
    localparam int          IR_W          = 4;
    localparam logic [3:0]  INS_EXTEST    = 4'h0;
    localparam logic [3:0]  INS_SAMPLE    = 4'h1;
    localparam logic [3:0]  INS_IDCODE    = 4'h2;
    localparam logic [3:0]  INS_CORE_DBG  = 4'h7;
    localparam logic [3:0]  INS_LOCKOUT   = 4'h8;
    localparam logic [3:0]  INS_BYPASS    = 4'hf;
    localparam logic [3:0]  IR_RESET      = INS_IDCODE;
    localparam logic [1:0]  IR_CAPTURE    = 2'h1;
    // data registers
    localparam int          DIV_W         = 7;
    localparam int          ID_W          = 32;
    localparam logic [6:0]  DIV_RESET     = 7'h00;
    // unsecure key word and where it lives in program memory
    localparam logic [15:0] KEY_UNSECURE  = 16'h0000;
    localparam logic [23:0] KEY_ADDR      = 24'h007ff7;
    // consecutive tms-high edges that always reach test-logic-reset
    localparam int          TLR_ONES      = 5;

    typedef enum logic [3:0] {
        TAP_TLR    = 4'h0, TAP_RTI    = 4'h1, TAP_SELDR  = 4'h3, TAP_CAPDR  = 4'h2,
        TAP_SHDR   = 4'h6, TAP_EX1DR  = 4'h7, TAP_PAUDR  = 4'h5, TAP_EX2DR  = 4'h4,
        TAP_UPDDR  = 4'hc, TAP_SELIR  = 4'hb, TAP_CAPIR  = 4'ha, TAP_SHIR   = 4'he,
        TAP_EX1IR  = 4'hf, TAP_PAUIR  = 4'hd, TAP_EX2IR  = 4'h9, TAP_UPDIR  = 4'h8
    } fsl_tap_state_type;

    typedef enum logic [1:0] {
        ER_IDLE = 2'h0,
        ER_BUSY = 2'h1,
        ER_DONE = 2'h3
    } fsl_erase_state_type;
endpackage

// ---- core/fsl_tap_if.sv ----
// link between the tap state machine and the instruction and data logic
`timescale 1ns/1ps
`default_nettype none
interface fsl_tap_if;
    import fsl_pkg::*;
    logic              tck;
    logic              tms;
    logic              tck_rise;
    logic              tck_fall;
    fsl_tap_state_type state;
    modport tap  (input tck, input tms, output tck_rise, output tck_fall, output state);
    modport user (output tck, output tms, input tck_rise, input tck_fall, input state);
endinterface
`default_nettype wire

// ---- core/fsl_tap.sv ----
// sixteen-state test access port controller sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module fsl_tap
    import fsl_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  resetn,
    fsl_tap_if.tap     tp
);
    logic              tck_q;
    fsl_tap_state_type state;
    fsl_tap_state_type next_state;
    logic [2:0]        ones;
    logic [2:0]        next_ones;

    // tck is synchronous to sys_clk, so a plain delayed copy finds its edges
    assign tp.tck_rise = tp.tck & ~tck_q;
    assign tp.tck_fall = ~tp.tck & tck_q;
    assign tp.state    = state;

    // standard state walk, advanced on each tck rising edge
    always_comb begin
        next_state = state;
        next_ones  = ones;
        if (tp.tck_rise) begin
            next_ones = tp.tms ? ((ones == 3'(TLR_ONES)) ? ones : ones + 3'h1) : 3'h0;
            unique case (state)
                TAP_TLR:   next_state = tp.tms ? TAP_TLR   : TAP_RTI;
                TAP_RTI:   next_state = tp.tms ? TAP_SELDR : TAP_RTI;
                TAP_SELDR: next_state = tp.tms ? TAP_SELIR : TAP_CAPDR;
                TAP_CAPDR: next_state = tp.tms ? TAP_EX1DR : TAP_SHDR;
                TAP_SHDR:  next_state = tp.tms ? TAP_EX1DR : TAP_SHDR;
                TAP_EX1DR: next_state = tp.tms ? TAP_UPDDR : TAP_PAUDR;
                TAP_PAUDR: next_state = tp.tms ? TAP_EX2DR : TAP_PAUDR;
                TAP_EX2DR: next_state = tp.tms ? TAP_UPDDR : TAP_SHDR;
                TAP_UPDDR: next_state = tp.tms ? TAP_SELDR : TAP_RTI;
                TAP_SELIR: next_state = tp.tms ? TAP_TLR   : TAP_CAPIR;
                TAP_CAPIR: next_state = tp.tms ? TAP_EX1IR : TAP_SHIR;
                TAP_SHIR:  next_state = tp.tms ? TAP_EX1IR : TAP_SHIR;
                TAP_EX1IR: next_state = tp.tms ? TAP_UPDIR : TAP_PAUIR;
                TAP_PAUIR: next_state = tp.tms ? TAP_EX2IR : TAP_PAUIR;
                TAP_EX2IR: next_state = tp.tms ? TAP_UPDIR : TAP_SHIR;
                TAP_UPDIR: next_state = tp.tms ? TAP_SELDR : TAP_RTI;
            endcase
        end
    end

    // device reset also resets the tap
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tck_q <= 1'b0;
            state <= TAP_TLR;
            ones  <= 3'h0;
        end else begin
            tck_q <= tp.tck;
            state <= next_state;
            ones  <= next_ones;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    five_ones_tlr_a: assert property (ones == 3'(TLR_ONES) |-> state == TAP_TLR)
        else $error("five tms-high edges did not reach reset state");
    idle_hold_a: assert property (state == TAP_RTI && tp.tck_rise && !tp.tms
        |=> state == TAP_RTI)
        else $error("tap left idle with tms low");
endmodule
`default_nettype wire

// ---- core/fsl_lockout.sv ----
// flash security gate, jtag instruction and data registers, lockout recovery erase
`timescale 1ns/1ps
`default_nettype none
module fsl_lockout
    import fsl_pkg::*;
#(
    parameter logic [31:0] IDCODE_VALUE = 32'h0000_0001  // arbitrary value
) (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tdi,
    output logic                   tdo,
    output logic                   tdo_oe,
    input  wire logic              flash_cfg_secure,
    input  wire logic [15:0]       flash_key_word,
    output logic [23:0]            flash_key_addr,
    output logic                   secured,
    output logic                   core_dbg_en,
    output logic                   core_dbg_sel,
    input  wire logic              core_dbg_tdo,
    input  wire logic              dbg_flash_req,
    output logic                   dbg_flash_grant,
    output logic                   dbg_flash_reject,
    output logic                   bsr_sel,
    input  wire logic              bsr_tdo,
    output logic                   dr_capture,
    output logic                   dr_shift,
    output logic                   dr_update,
    output logic                   erase_req,
    output logic [DIV_W-1:0]       erase_clk_div,
    input  wire logic              erase_done,
    output logic                   prot_clear,
    output logic                   recovery_done
);
    fsl_tap_if tp ();

    assign tp.tck = tck;
    assign tp.tms = tms;

    fsl_tap u_tap (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .tp      (tp)
    );

    logic [IR_W-1:0]     ir;
    logic [IR_W-1:0]     next_ir;
    logic [IR_W-1:0]     ir_sh;
    logic [IR_W-1:0]     next_ir_sh;
    logic [ID_W-1:0]     dr_sh;
    logic [ID_W-1:0]     next_dr_sh;
    logic [DIV_W-1:0]    div;
    logic [DIV_W-1:0]    next_div;
    logic                div_loaded;
    logic                next_div_loaded;
    logic                next_tdo;
    logic                next_tdo_oe;
    logic                rise;
    fsl_tap_state_type   st;
    fsl_tap_state_type   st_q;

    assign rise = tp.tck_rise;
    assign st   = tp.state;

    // instruction path; tlr forces idcode so id is readable straight after boot
    always_comb begin
        next_ir    = ir;
        next_ir_sh = ir_sh;
        if (st == TAP_TLR) begin
            next_ir = IR_RESET;
        end else if (rise) begin
            if (st == TAP_CAPIR) begin
                next_ir_sh = {{(IR_W-2){1'b0}}, IR_CAPTURE};
            end else if (st == TAP_SHIR) begin
                next_ir_sh = {tdi, ir_sh[IR_W-1:1]};
            end else if (st == TAP_UPDIR) begin
                next_ir = ir_sh;
            end
        end
    end

    // data path; each instruction selects its own chain length
    always_comb begin
        next_dr_sh      = dr_sh;
        next_div        = div;
        next_div_loaded = div_loaded;
        if (st == TAP_TLR || (rise && st == TAP_UPDIR)) begin
            next_div_loaded = 1'b0;
        end
        if (rise && st == TAP_CAPDR) begin
            unique case (ir)
                INS_IDCODE:  next_dr_sh = IDCODE_VALUE;
                INS_LOCKOUT: next_dr_sh = {{(ID_W-DIV_W){1'b0}}, div};
                default:     next_dr_sh = '0;
            endcase
        end else if (rise && st == TAP_SHDR) begin
            unique case (ir)
                INS_IDCODE:  next_dr_sh = {tdi, dr_sh[ID_W-1:1]};
                INS_LOCKOUT: next_dr_sh = {{(ID_W-DIV_W){1'b0}}, tdi, dr_sh[DIV_W-1:1]};
                default:     next_dr_sh = {{(ID_W-1){1'b0}}, tdi};
            endcase
        end else if (rise && st == TAP_UPDDR && ir == INS_LOCKOUT) begin
            next_div        = dr_sh[DIV_W-1:0];
            next_div_loaded = 1'b1;
        end
    end

    // boundary scan and core debug chains are external and share the strobes
    assign bsr_sel      = (ir == INS_EXTEST) || (ir == INS_SAMPLE);
    assign core_dbg_sel = (ir == INS_CORE_DBG) && !secured;
    assign dr_capture   = rise && st == TAP_CAPDR;
    assign dr_shift     = rise && st == TAP_SHDR;
    assign dr_update    = rise && st == TAP_UPDDR;

    // tdo changes on the falling tck edge so the host samples a settled bit
    always_comb begin
        next_tdo    = tdo;
        next_tdo_oe = tdo_oe;
        if (tp.tck_fall) begin
            next_tdo_oe = (st == TAP_SHIR) || (st == TAP_SHDR);
            if (st == TAP_SHIR) begin
                next_tdo = ir_sh[0];
            end else if (st == TAP_SHDR) begin
                next_tdo = core_dbg_sel ? core_dbg_tdo : (bsr_sel ? bsr_tdo : dr_sh[0]);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ir         <= IR_RESET;
            ir_sh      <= '0;
            dr_sh      <= '0;
            div        <= DIV_RESET;
            div_loaded <= 1'b0;
            tdo        <= 1'b0;
            tdo_oe     <= 1'b0;
            st_q       <= TAP_TLR;
        end else begin
            ir         <= next_ir;
            ir_sh      <= next_ir_sh;
            dr_sh      <= next_dr_sh;
            div        <= next_div;
            div_loaded <= next_div_loaded;
            tdo        <= next_tdo;
            tdo_oe     <= next_tdo_oe;
            st_q       <= st;
        end
    end

    // lockout erase sequencer
    fsl_erase_state_type er;
    fsl_erase_state_type next_er;
    logic                start;
    logic                next_prot_clear;

    // only the entry into idle starts it, so lingering in idle cannot retrigger
    assign start = (st == TAP_RTI) && (st_q != TAP_RTI)
                   && (ir == INS_LOCKOUT) && div_loaded;

    always_comb begin
        next_er         = er;
        next_prot_clear = 1'b0;
        unique case (er)
            ER_IDLE: if (start) next_er = ER_BUSY;
            // flash erase cannot be cut short, so leaving idle does not abort
            ER_BUSY: if (erase_done) begin
                next_er         = ER_DONE;
                next_prot_clear = 1'b1;
            end
            ER_DONE: next_er = ER_DONE;
            default: next_er = ER_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            er         <= ER_IDLE;
            prot_clear <= 1'b0;
        end else begin
            er         <= next_er;
            prot_clear <= next_prot_clear;
        end
    end

    assign erase_req     = (er == ER_BUSY);
    assign erase_clk_div = div;
    assign recovery_done = (er == ER_DONE);

    // security state is caught on the first edge after reset release and then frozen
    logic cap_done;
    logic next_cap_done;
    logic next_secured;

    assign flash_key_addr = KEY_ADDR;

    always_comb begin
        next_cap_done = 1'b1;
        next_secured  = secured;
        if (!cap_done) begin
            next_secured = flash_cfg_secure && (flash_key_word != KEY_UNSECURE);
        end
    end

    // secured from reset so nothing leaks before the flash state is known
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cap_done <= 1'b0;
            secured  <= 1'b1;
        end else begin
            cap_done <= next_cap_done;
            secured  <= next_secured;
        end
    end

    // core debug gate; program execution is not touched by this block
    assign core_dbg_en      = !secured;
    assign dbg_flash_grant  = dbg_flash_req && !secured;
    assign dbg_flash_reject = dbg_flash_req && secured;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    core_dbg_off_a: assert property (secured |-> !core_dbg_en)
        else $error("core debug enabled while secured");
    flash_read_a: assert property (dbg_flash_req && !secured |-> dbg_flash_grant)
        else $error("unsecured flash read not granted");
    idcode_cap_a: assert property (rise && st == TAP_CAPDR && ir == INS_IDCODE
        |=> dr_sh == IDCODE_VALUE)
        else $error("idcode not captured");
    flash_block_a: assert property (secured |-> !dbg_flash_grant && !core_dbg_sel
        && (dbg_flash_req == dbg_flash_reject))
        else $error("flash reachable while secured");
    sec_until_reset_a: assert property (cap_done && er == ER_DONE |=> $stable(secured))
        else $error("security changed before reset");
    div_capture_a: assert property (rise && st == TAP_UPDDR && ir == INS_LOCKOUT
        |=> div == $past(dr_sh[DIV_W-1:0]) && div_loaded)
        else $error("divider not captured at update");
    erase_start_a: assert property (er == ER_IDLE && start |=> erase_req ##1 erase_req
        || $past(erase_done))
        else $error("erase did not start on idle entry");
    erase_end_a: assert property (erase_req && erase_done |=> prot_clear && recovery_done
        ##1 !prot_clear)
        else $error("erase completion mishandled");
    reset_idle_a: assert property (!cap_done |-> er == ER_IDLE && !erase_req)
        else $error("erase state survived reset");
    key_capture_a: assert property (!cap_done |=> secured ==
        ($past(flash_cfg_secure) && $past(flash_key_word) != KEY_UNSECURE))
        else $error("security capture wrong");

    erase_run_c:  cover property (er == ER_BUSY ##[1:50] er == ER_DONE);
    id_read_c:    cover property (rise && st == TAP_CAPDR && ir == INS_IDCODE);
    key_open_c:   cover property (!cap_done && flash_cfg_secure ##1 !secured);
    dbg_select_c: cover property (core_dbg_sel && dr_shift);
endmodule
`default_nettype wire

// ---- tb/fsl_jtag_host.sv ----
// jtag host model that walks the tap and shifts instruction and data registers
`timescale 1ns/1ps
`default_nettype none
module fsl_jtag_host
    import fsl_pkg::*;
(
    input  wire logic sys_clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one tck period: three sys_clk low, four high counting the next call's first wait; tdo taken just before the rise
    task automatic step(input logic ms, input logic di, output logic dout);
        @(negedge sys_clk);
        tck = 1'b0;
        tms = ms;
        tdi = di;
        repeat (3) @(negedge sys_clk);
        dout = tdo;
        tck = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask

    // between frames tck stands low, tms stays low so the tap holds run-test/idle
    task automatic park();
        @(negedge sys_clk);
        tck = 1'b0;
        tdi = ~tdi; // stale data never looks valid
    endtask

    // tms high for five rises reaches test-logic-reset from any state
    task automatic reset_tap();
        logic d;
        repeat (TLR_ONES) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
        park();
    endtask

    // shift n bits lsb first, starting and ending in run-test/idle
    task automatic shift(input logic is_ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        logic d;
        dout = '0;
        step(1'b1, 1'b0, d);
        if (is_ir) begin
            step(1'b1, 1'b0, d);
        end
        step(1'b0, 1'b0, d);
        step(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
        park();
    endtask
endmodule
`default_nettype wire

// ---- tb/fsl_lockout_bench.sv ----
// self-checking bench for the flash security gate and lockout recovery
`timescale 1ns/1ps
`default_nettype none
module fsl_lockout_bench;
    import fsl_pkg::*;
    localparam logic [31:0] ID_EXP = 32'h1357_9bdf; // arbitrary value
    localparam int          LIMIT  = 20000;
    logic              sys_clk = 1'b0;
    logic              resetn = 1'b0;
    logic              tck, tms, tdi, tdo, tdo_oe, secured, core_dbg_en, core_dbg_sel;
    logic              flash_cfg_secure = 1'b1;
    logic [15:0]       flash_key_word = 16'h0001;
    logic [23:0]       flash_key_addr;
    logic              core_dbg_tdo = 1'b0;
    logic              bsr_tdo = 1'b0;
    logic              dbg_flash_req = 1'b0;
    logic              erase_done = 1'b0;
    logic              dbg_flash_grant, dbg_flash_reject, bsr_sel, dr_capture, dr_shift;
    logic              dr_update, erase_req, prot_clear, recovery_done;
    logic [DIV_W-1:0]  erase_clk_div, div, exp_div;
    logic [DIV_W-1:0]  exp_q[$];
    logic [31:0]       got;
    logic [15:0]       key;
    logic [3:0]        codes[4] = '{INS_EXTEST, INS_SAMPLE, INS_CORE_DBG, INS_BYPASS};
    int                seed = 93505;
    int                line_seed = 93505;
    int                err_total = 0;
    int                checks = 0;
    int                cycles = 0;
    int                n_cap = 0;
    int                n_shf = 0;
    int                n_upd = 0;

    always #2 sys_clk = ~sys_clk;

    fsl_lockout #(.IDCODE_VALUE(ID_EXP)) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .flash_cfg_secure(flash_cfg_secure), .flash_key_word(flash_key_word),
        .flash_key_addr(flash_key_addr), .secured(secured), .core_dbg_en(core_dbg_en),
        .core_dbg_sel(core_dbg_sel), .core_dbg_tdo(core_dbg_tdo),
        .dbg_flash_req(dbg_flash_req), .dbg_flash_grant(dbg_flash_grant),
        .dbg_flash_reject(dbg_flash_reject), .bsr_sel(bsr_sel), .bsr_tdo(bsr_tdo),
        .dr_capture(dr_capture), .dr_shift(dr_shift), .dr_update(dr_update),
        .erase_req(erase_req), .erase_clk_div(erase_clk_div), .erase_done(erase_done),
        .prot_clear(prot_clear), .recovery_done(recovery_done));

    fsl_jtag_host host (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard: a run far beyond the planned tck traffic counts as a failure
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            finish_test();
        end
    end

    // boundary and core chains give noise so a wrong tdo mux shows up
    always @(negedge sys_clk) begin
        {bsr_tdo, core_dbg_tdo} = 2'($random(line_seed));
    end

    // data strobe tally; each strobe stands one sys_clk, so one look a cycle sees it one time
    always @(negedge sys_clk) begin
        if (dr_capture === 1'b1) begin
            n_cap++;
        end
        if (dr_shift === 1'b1) begin
            n_shf++;
        end
        if (dr_update === 1'b1) begin
            n_upd++;
        end
    end

    // result watcher: each protection-clear pulse takes the oldest expected divider
    always @(negedge sys_clk) begin
        if (prot_clear === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected protection clear", prot_clear, 0);
            end else begin
                exp_div = exp_q.pop_front();
                check("erase divider", erase_clk_div, exp_div);
                check("recovery done", recovery_done, 1);
            end
        end
    end

    // security is only sampled at reset, so every case starts with one
    task automatic do_reset(input logic sec, input logic [15:0] k);
        @(negedge sys_clk);
        resetn = 1'b0;
        flash_cfg_secure = sec;
        flash_key_word = k;
        repeat (12) @(negedge sys_clk);
        check("secured in reset", secured, 1);
        check("erase request in reset", erase_req, 0);
        resetn = 1'b1;
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic check_gate(input logic sec);
        check("secured", secured, sec);
        check("core debug enable", core_dbg_en, !sec);
        dbg_flash_req = 1'b1;
        @(negedge sys_clk);
        check("flash grant", dbg_flash_grant, !sec);
        check("flash reject", dbg_flash_reject, sec);
        dbg_flash_req = 1'b0;
    endtask

    // extest, sample, core debug and bypass, with the chain selects each must give
    task automatic sel_scan(input logic sec);
        for (int i = 0; i < 4; i++) begin
            host.shift(1'b1, IR_W, {28'h0, codes[i]}, got);
            check("ir capture", got, {30'h0, IR_CAPTURE});
            check("boundary select", bsr_sel, codes[i] inside {INS_EXTEST, INS_SAMPLE});
            check("core chain select", core_dbg_sel, codes[i] == INS_CORE_DBG && !sec);
        end
    endtask

    initial begin
        key = 16'($random(seed)) | 16'h0100;
        do_reset(1'b1, key);
        check_gate(1'b1);
        check("key address", flash_key_addr, {8'h0, KEY_ADDR});
        host.reset_tap();
        check("tdo enable idle", tdo_oe, 0);
        host.shift(1'b0, ID_W, 32'h0, got);
        check("id register", got, ID_EXP);
        check("capture strobes", n_cap, 1);
        check("shift strobes", n_shf, ID_W);
        check("update strobes", n_upd, 1);
        sel_scan(1'b1);
        // lockout recovery while secured, random divider and erase length
        div = 7'($random(seed));
        host.shift(1'b1, IR_W, {28'h0, INS_LOCKOUT}, got);
        host.shift(1'b0, DIV_W, {25'h0, div}, got);
        exp_q.push_back(div);
        for (int w = 0; w < 8 && erase_req !== 1'b1; w++) begin
            @(negedge sys_clk);
        end
        check("erase started", erase_req, 1);
        repeat (2 + ($unsigned($random(seed)) % 20)) @(negedge sys_clk);
        check("erase held", erase_req, 1);
        erase_done = 1'b1;
        @(negedge sys_clk);
        erase_done = 1'b0;
        @(negedge sys_clk);
        check("clear is one pulse", prot_clear, 0);
        check("erase finished", erase_req, 0);
        check("still secured", secured, 1);
        check("notes used", exp_q.size(), 0);
        // erased configuration field takes effect only at the next reset
        host.reset_tap();
        do_reset(1'b0, 16'hffff);
        // device reset leaves the tap in test-logic-reset; the host walks it back to idle
        host.reset_tap();
        check("recovery cleared", recovery_done, 0);
        check_gate(1'b0);
        sel_scan(1'b0);
        // key word zero unsecures with configuration still secure
        do_reset(1'b1, KEY_UNSECURE);
        check_gate(1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
